/* File: core/jsp_pkg.sv */
package jsp_pkg;

	// ------------------------------------------------------------
	// Configuration space
	// ------------------------------------------------------------
	localparam logic [7:0]  CFG_IDX_ACTIVATE = 8'h30;
	localparam logic [7:0]  CFG_IDX_BASE_HI  = 8'h60;
	localparam logic [7:0]  CFG_IDX_BASE_LO  = 8'h61;
	localparam logic [7:0]  CFG_IDX_PWR_CTL  = 8'h22;
	localparam int          PWR_STICK_BIT    = 2;
	localparam int          ACTIVATE_BIT     = 0;
	localparam logic [15:0] BASE_RESET       = 16'h0000;

	// ------------------------------------------------------------
	// Runtime register
	// ------------------------------------------------------------
	localparam logic [15:0] STATE_OFFSET     = 16'h0000;
	localparam logic [7:0]  STATE_RESET      = 8'h00;

	// ------------------------------------------------------------
	// Timing and axis count
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int DISCHARGE_NS  = 1000;
	localparam int DISCHARGE_CYC = (DISCHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int AXIS_COUNT    = 4;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] addr;
		logic        rd;
		logic        wr;
	} jsp_io_req_t;

	typedef struct packed {
		logic [3:0] buttons;
		logic [3:0] axes;
	} jsp_state_t;

	typedef enum logic [1:0] {
		AX_IDLE,
		AX_DISCHARGE,
		AX_CHARGE
	} jsp_axis_state_t;

endpackage

/* File: core/jsp_axis_timer.sv */
`timescale 1ns/100ps

module jsp_axis_timer
	import jsp_pkg::*;
#(
	parameter int DISCH_CYC = DISCHARGE_CYC
) (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic start,
	input  wire logic thresh,
	output logic      axis_out,
	output logic      pin_oe
);

	localparam int          CW      = $clog2(DISCH_CYC + 1);
	localparam logic [CW-1:0] CNT_LAST = CW'(DISCH_CYC - 1);

	jsp_axis_state_t state_q, state_d;
	logic [CW-1:0]   cnt_q, cnt_d;
	logic            out_q, out_d;
	logic            oe_q, oe_d;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		out_d   = out_q;
		oe_d    = oe_q;
		if (start) begin
			// A restart wins over everything: capacitor is dumped first
			state_d = AX_DISCHARGE;
			cnt_d   = '0;
			out_d   = 1'b1;
			oe_d    = 1'b1;
		end else begin
			unique case (state_q)
				AX_IDLE: begin
					out_d = 1'b0;
					oe_d  = 1'b1;
				end
				AX_DISCHARGE: begin
					if (cnt_q == CNT_LAST) begin
						state_d = AX_CHARGE;
						oe_d    = 1'b0;
					end else begin
						cnt_d = cnt_q + CW'(1);
					end
				end
				AX_CHARGE: begin
					if (thresh) begin
						// Crossing the comparator ends the measurement
						state_d = AX_IDLE;
						out_d   = 1'b0;
						oe_d    = 1'b1;
					end
				end
				default: begin
					state_d = AX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= AX_IDLE;
			cnt_q   <= '0;
			out_q   <= 1'b0;
			oe_q    <= 1'b1;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			out_q   <= out_d;
			oe_q    <= oe_d;
		end
	end

	assign axis_out = out_q;
	assign pin_oe   = oe_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_THRESH_ENDS: assert property (@(posedge mclk) disable iff (rst)
		(state_q == AX_CHARGE && thresh && !start) |=> (!axis_out && pin_oe))
		else $error("axis did not end on threshold");

	AST_DISCH_LEN: assert property (@(posedge mclk) disable iff (rst)
		(state_q == AX_DISCHARGE && cnt_q == CNT_LAST && !start) |=> (!pin_oe && axis_out))
		else $error("discharge did not end after its count");

	AST_START_DRIVES: assert property (@(posedge mclk) disable iff (rst)
		start |=> (pin_oe && axis_out && state_q == AX_DISCHARGE))
		else $error("restart did not drive the pin low");

endmodule

/* File: core/jsp_stick_port.sv */
`timescale 1ns/100ps

module jsp_stick_port
	import jsp_pkg::*;
#(
	parameter int DISCH_CYC = DISCHARGE_CYC
) (
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire jsp_io_req_t           io_req,
	output logic      [7:0]            io_rdata,
	output logic                       io_rd_claim,
	input  wire logic                  cfg_wr,
	input  wire logic                  cfg_rd,
	input  wire logic                  cfg_global,
	input  wire logic [7:0]            cfg_index,
	input  wire logic [7:0]            cfg_wdata,
	output logic      [7:0]            cfg_rdata,
	input  wire logic [AXIS_COUNT-1:0] rc_pin_in,
	output logic      [AXIS_COUNT-1:0] rc_pin_out,
	output logic      [AXIS_COUNT-1:0] rc_pin_oe,
	input  wire logic [AXIS_COUNT-1:0] button_pin
);

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	logic [7:0] base_hi_q, base_hi_d;
	logic [7:0] base_lo_q, base_lo_d;
	logic       activate_q, activate_d;
	logic [7:0] cfg_rdata_q, cfg_rdata_d;
	logic       wr_act, wr_pwr;

	assign wr_act = cfg_wr && !cfg_global && cfg_index == CFG_IDX_ACTIVATE;
	assign wr_pwr = cfg_wr && cfg_global && cfg_index == CFG_IDX_PWR_CTL;

	always_comb begin
		base_hi_d   = base_hi_q;
		base_lo_d   = base_lo_q;
		activate_d  = activate_q;
		cfg_rdata_d = 8'h00;
		if (cfg_wr && !cfg_global && cfg_index == CFG_IDX_BASE_HI) begin
			base_hi_d = cfg_wdata;
		end
		if (cfg_wr && !cfg_global && cfg_index == CFG_IDX_BASE_LO) begin
			base_lo_d = cfg_wdata;
		end
		// One flop serves both views, so the mirror can never drift
		if (wr_act) begin
			activate_d = cfg_wdata[ACTIVATE_BIT];
		end else if (wr_pwr) begin
			activate_d = cfg_wdata[PWR_STICK_BIT];
		end
		if (cfg_rd) begin
			if (cfg_global) begin
				if (cfg_index == CFG_IDX_PWR_CTL) begin
					cfg_rdata_d[PWR_STICK_BIT] = activate_q;
				end
			end else begin
				unique case (cfg_index)
					CFG_IDX_BASE_HI:  cfg_rdata_d = base_hi_q;
					CFG_IDX_BASE_LO:  cfg_rdata_d = base_lo_q;
					CFG_IDX_ACTIVATE: cfg_rdata_d[ACTIVATE_BIT] = activate_q;
					default:          cfg_rdata_d = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			base_hi_q   <= BASE_RESET[15:8];
			base_lo_q   <= BASE_RESET[7:0];
			activate_q  <= 1'b0;
			cfg_rdata_q <= 8'h00;
		end else begin
			base_hi_q   <= base_hi_d;
			base_lo_q   <= base_lo_d;
			activate_q  <= activate_d;
			cfg_rdata_q <= cfg_rdata_d;
		end
	end

	assign cfg_rdata = cfg_rdata_q;

	// ------------------------------------------------------------
	// Host I/O decode
	// ------------------------------------------------------------
	logic [15:0] base_addr;
	logic        addr_hit;
	logic        rd_hit;
	logic        wr_hit;
	logic        wr_hit_q, wr_hit_d;
	logic        timer_start;

	assign base_addr = {base_hi_q, base_lo_q};
	// Nothing is decoded while the unit is inactive
	assign addr_hit  = activate_q && io_req.addr == base_addr + STATE_OFFSET;
	assign rd_hit    = addr_hit && io_req.rd;
	assign wr_hit    = addr_hit && io_req.wr;

	// Strobe is tracked while it stays high, whatever the address; the write data is never looked at
	always_comb begin
		wr_hit_d = wr_hit || (wr_hit_q && io_req.wr);
	end

	// Restart fires as the strobe goes inactive, data value irrelevant
	assign timer_start = wr_hit_q && !io_req.wr;

	always_ff @(posedge mclk) begin
		if (rst) begin
			wr_hit_q <= 1'b0;
		end else begin
			wr_hit_q <= wr_hit_d;
		end
	end

	// ------------------------------------------------------------
	// Buttons
	// ------------------------------------------------------------
	logic [AXIS_COUNT-1:0] btn_meta_q, btn_meta_d;
	logic [AXIS_COUNT-1:0] btn_q, btn_d;

	always_comb begin
		btn_meta_d = button_pin;
		btn_d      = btn_meta_q;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			btn_meta_q <= '0;
			btn_q      <= '0;
		end else begin
			btn_meta_q <= btn_meta_d;
			btn_q      <= btn_d;
		end
	end

	// ------------------------------------------------------------
	// Axis timers
	// ------------------------------------------------------------
	logic [AXIS_COUNT-1:0] axis_out;
	logic [AXIS_COUNT-1:0] axis_oe;

	// Bit order X1, Y1, X2, Y2
	for (genvar i = 0; i < AXIS_COUNT; i++) begin : g_axis
		jsp_axis_timer #(
			.DISCH_CYC (DISCH_CYC)
		) u_timer (
			.mclk     (mclk),
			.rst      (rst),
			.start    (timer_start),
			.thresh   (rc_pin_in[i]),
			.axis_out (axis_out[i]),
			.pin_oe   (axis_oe[i])
		);
	end

	// Pins are only ever pulled low; charging is done by the external RC
	assign rc_pin_out = '0;
	assign rc_pin_oe  = axis_oe;

	// ------------------------------------------------------------
	// State byte read
	// ------------------------------------------------------------
	jsp_state_t state_w;
	logic [7:0] rdata_q, rdata_d;
	logic       claim_q, claim_d;

	always_comb begin
		state_w.axes    = axis_out;
		state_w.buttons = btn_q;
		rdata_d         = rd_hit ? state_w : STATE_RESET;
		claim_d         = rd_hit;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_q <= STATE_RESET;
			claim_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			claim_q <= claim_d;
		end
	end

	assign io_rdata    = rdata_q;
	assign io_rd_claim = claim_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	AST_READ_DATA: assert property (
		rd_hit |=> (io_rd_claim && io_rdata == $past(state_w)))
		else $error("read at base did not return state byte");

	AST_NO_DECODE: assert property (
		(!activate_q && (io_req.rd || io_req.wr)) |=> (!io_rd_claim && !wr_hit_q))
		else $error("inactive unit decoded its address");

	AST_TRAIL_START: assert property (
		timer_start |=> (&rc_pin_oe && &axis_out && rc_pin_out == '0))
		else $error("trailing edge did not restart all axes");

	AST_NO_LEAD: assert property (
		timer_start |-> ($past(io_req.wr) && !io_req.wr))
		else $error("restart fired on leading edge");

	AST_MIRROR: assert property (
		(wr_pwr && !wr_act) |=> (activate_q == $past(cfg_wdata[PWR_STICK_BIT])))
		else $error("power bit did not update activate");

	AST_BASE_HI: assert property (
		(cfg_wr && !cfg_global && cfg_index == CFG_IDX_BASE_HI)
		|=> (base_addr[15:8] == $past(cfg_wdata)))
		else $error("high base byte not taken");

	AST_BUTTONS: assert property (
		$past(!rst) |-> ##1 (state_w.buttons == $past(button_pin, 2)))
		else $error("button level not passed through");

	AST_RESTART_ONCE: assert property (
		timer_start |=> !timer_start)
		else $error("one write gave two restarts");

	// Configuration views and idle answers; these catch a swapped byte or a lost mirror
	AST_BASE_LO: assert property (
		(cfg_wr && !cfg_global && cfg_index == CFG_IDX_BASE_LO)
		|=> (base_addr[7:0] == $past(cfg_wdata)))
		else $error("low base byte not taken");

	AST_BASE_HOLD: assert property (
		!(cfg_wr && !cfg_global &&
		  (cfg_index == CFG_IDX_BASE_HI || cfg_index == CFG_IDX_BASE_LO))
		|=> $stable(base_addr))
		else $error("base address moved without a write");

	AST_ACT_LOCAL: assert property (
		wr_act |=> (activate_q == $past(cfg_wdata[ACTIVATE_BIT])))
		else $error("activate bit not taken");

	AST_ACT_HOLD: assert property (
		!(wr_act || wr_pwr) |=> $stable(activate_q))
		else $error("activate moved without a write");

	AST_PWR_VIEW: assert property (
		(cfg_rd && cfg_global && cfg_index == CFG_IDX_PWR_CTL)
		|=> (cfg_rdata[PWR_STICK_BIT] == $past(activate_q)))
		else $error("power bit does not show activate");

	AST_ACT_VIEW: assert property (
		(cfg_rd && !cfg_global && cfg_index == CFG_IDX_ACTIVATE)
		|=> (cfg_rdata[ACTIVATE_BIT] == $past(activate_q)))
		else $error("activate bit reads wrong");

	AST_CFG_IDLE: assert property (
		!cfg_rd |=> (cfg_rdata == '0))
		else $error("config data without a read");

	AST_BYTE_MAP: assert property (
		rd_hit |=> (io_rdata[3:0] == $past(axis_out)
			&& io_rdata[7:4] == $past(btn_q)))
		else $error("state byte fields out of place");

	AST_IDLE_READ: assert property (
		!rd_hit |=> (!io_rd_claim && io_rdata == STATE_RESET))
		else $error("read answer without a hit");

	// A restart needs a hit write first, so a unit inactive for the whole strobe never restarts the axis timers
	AST_DEAD_NO_START: assert property (
		(!activate_q && !wr_hit_q) |=> !timer_start)
		else $error("inactive unit restarted the timers");

	AST_PIN_LOW: assert property (
		((~axis_out & ~rc_pin_oe) == '0))
		else $error("axis ended without driving its pin");

	COV_WRITE_RESTART: cover property (wr_hit ##1 !io_req.wr ##1 &axis_out);
	COV_READ_HIT: cover property (rd_hit ##1 io_rd_claim);
	COV_AXIS_DONE: cover property ($fell(axis_out[0]));
	COV_MIRROR_OFF: cover property (wr_pwr ##1 !activate_q);
	COV_MIDRUN_RESTART: cover property (timer_start && !(&rc_pin_oe));

endmodule

/* File: verification/jsp_rc_model.sv */
`timescale 1ns/100ps

// ------------------------------------------------------------
// RC network and threshold comparator, one per axis
// ------------------------------------------------------------
module jsp_rc_model
	import jsp_pkg::*;
#(
	parameter int CHG_CYC [AXIS_COUNT] = '{20, 30, 40, 50}
) (
	input  wire logic                  mclk,
	input  wire logic [AXIS_COUNT-1:0] rc_oe,
	output logic      [AXIS_COUNT-1:0] rc_above
);
	int cnt [AXIS_COUNT];

	// Driving the pin low empties the capacitor at once; real parts need some time
	always_ff @(posedge mclk) begin
		for (int i = 0; i < AXIS_COUNT; i++) begin
			if (rc_oe[i]) begin
				cnt[i] <= 0;
			end else if (cnt[i] < CHG_CYC[i]) begin
				cnt[i] <= cnt[i] + 1;
			end
		end
	end

	always_comb begin
		for (int i = 0; i < AXIS_COUNT; i++) begin
			rc_above[i] = !rc_oe[i] && (cnt[i] >= CHG_CYC[i]);
		end
	end
endmodule

/* File: verification/tb.sv */
`timescale 1ns/100ps

module tb
	import jsp_pkg::*;
;
	localparam int          DISCH = 4;
	localparam int          CHG [AXIS_COUNT] = '{20, 30, 40, 50};
	localparam logic [15:0] BASE  = 16'h1234;

	logic        mclk;
	logic        rst;
	jsp_io_req_t io_req;
	logic [7:0]  io_rdata;
	logic        io_rd_claim;
	logic        cfg_wr;
	logic        cfg_rd;
	logic        cfg_global;
	logic [7:0]  cfg_index;
	logic [7:0]  cfg_wdata;
	logic [7:0]  cfg_rdata;
	logic [3:0]  rc_pin_in;
	logic [3:0]  rc_pin_oe;
	logic [3:0]  rc_pin_out;
	logic [3:0]  button_pin;
	int          err_count;
	int          checks_done;
	int          cyc;

	jsp_stick_port #(.DISCH_CYC(DISCH)) jsp_stick_port_i (
		.mclk(mclk), .rst(rst), .io_req(io_req), .io_rdata(io_rdata),
		.io_rd_claim(io_rd_claim), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_global(cfg_global), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .rc_pin_in(rc_pin_in), .rc_pin_out(rc_pin_out),
		.rc_pin_oe(rc_pin_oe), .button_pin(button_pin)
	);

	jsp_rc_model #(.CHG_CYC(CHG)) jsp_rc_model_i (
		.mclk(mclk), .rc_oe(rc_pin_oe), .rc_above(rc_pin_in)
	);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk) cyc++;

	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cfg_write(input logic g, input logic [7:0] idx, input logic [7:0] d);
		@(posedge mclk);
		cfg_global <= g;
		cfg_index  <= idx;
		cfg_wdata  <= d;
		cfg_wr     <= 1'b1;
		@(posedge mclk);
		cfg_wr     <= 1'b0;
	endtask

	task automatic cfg_read(input logic g, input logic [7:0] idx, output logic [7:0] d);
		@(posedge mclk);
		cfg_global <= g;
		cfg_index  <= idx;
		cfg_rd     <= 1'b1;
		@(posedge mclk);
		cfg_rd     <= 1'b0;
		#1 d = cfg_rdata;
	endtask

	task automatic io_read(input logic [15:0] a, output logic [8:0] r);
		@(posedge mclk);
		io_req <= '{addr: a, rd: 1'b1, wr: 1'b0};
		@(posedge mclk);
		io_req <= '{addr: a, rd: 1'b0, wr: 1'b0};
		#1 r = {io_rd_claim, io_rdata};
	endtask

	// Pins must not move while the strobe is still high
	task automatic io_write(input logic [15:0] a, input int hold, input logic [3:0] oe);
		@(posedge mclk);
		io_req <= '{addr: a, rd: 1'b0, wr: 1'b1};
		repeat (hold) begin
			@(posedge mclk);
			#1 check(rc_pin_oe, oe);
		end
		@(posedge mclk);
		io_req <= '{addr: a, rd: 1'b0, wr: 1'b0};
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic measure(input int hold, input logic [3:0] oe);
		int         t0;
		logic [8:0] r;
		logic [3:0] done;
		io_write(BASE, hold, oe);
		#1 t0 = cyc;
		repeat (2) @(posedge mclk);
		io_read(BASE, r);
		check(r, 9'h1af);
		check({rc_pin_oe, rc_pin_out}, 8'hf0);
		done = 4'h0;
		for (int k = 0; k < 200 && done != 4'hf; k++) begin
			io_read(BASE, r);
			for (int i = 0; i < AXIS_COUNT; i++) begin
				if (!done[i] && r[i] === 1'b0) begin
					done[i] = 1'b1;
					check(cyc - t0 >= DISCH + CHG[i] && cyc - t0 <= DISCH + CHG[i] + 10, 1);
				end
			end
		end
		check(done, 4'hf);
		check(r, 9'h1a0);
	endtask

	// The second write lands while every axis charges: pins stay released until it ends
	task automatic test_restart_midrun();
		io_write(BASE, 1, 4'hf);
		repeat (DISCH + 6) @(posedge mclk);
		#1 check(rc_pin_oe, 4'h0);
		measure(5, 4'h0);
	endtask

	task automatic test_config();
		logic [7:0] d;
		logic [8:0] r;
		io_read(BASE, r);
		check(r, 0);
		cfg_write(0, 8'h60, 8'h12);
		cfg_write(0, 8'h61, 8'h34);
		cfg_read(0, 8'h60, d);
		check(d, 8'h12);
		cfg_read(0, 8'h61, d);
		check(d, 8'h34);
		cfg_write(1, 8'h22, 8'h04);
		cfg_read(0, 8'h30, d);
		check(d[0], 1);
		cfg_write(0, 8'h30, 8'h00);
		cfg_read(1, 8'h22, d);
		check(d[2], 0);
		cfg_write(0, 8'h30, 8'h01);
		cfg_read(1, 8'h22, d);
		check(d[2], 1);
		io_read(16'h3412, r);
		check(r, 0);
	endtask

	task automatic test_buttons_and_refusals();
		logic [8:0] r;
		@(posedge mclk);
		button_pin <= 4'h5;
		repeat (3) @(posedge mclk);
		io_read(BASE, r);
		check(r, 9'h150);
		io_write(BASE + 16'h1, 2, 4'hf);
		repeat (DISCH + 6) @(posedge mclk);
		#1 check(rc_pin_oe, 4'hf);
		cfg_write(1, 8'h22, 8'h00);
		io_write(BASE, 2, 4'hf);
		repeat (DISCH + 6) @(posedge mclk);
		#1 check(rc_pin_oe, 4'hf);
		io_read(BASE, r);
		check(r, 0);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		#200us;
		err_count++;
		finish_test();
	end

	initial begin
		rst = 1'b1;
		io_req = '{addr: 16'h0000, rd: 1'b0, wr: 1'b0};
		{cfg_wr, cfg_rd, cfg_global, cfg_index, cfg_wdata} = '0;
		button_pin = 4'ha;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		test_config();
		measure(3, 4'hf);
		test_restart_midrun();
		test_buttons_and_refusals();
		finish_test();
	end
endmodule
